// ---- rtl/ssf_defines.svh ----
`ifndef SSF_DEFINES_SVH
`define SSF_DEFINES_SVH

`define SSF_ADDR_W      5
`define SSF_STR_AW      4
`define SSF_STR_WORDS   16
`define SSF_CI_END      6'h20

`define SSF_REG_CTRL    5'h10
`define SSF_REG_STAT    5'h11
`define SSF_REG_RES_LO  5'h12
`define SSF_REG_RES_HI  5'h13
`define SSF_REG_ERR     5'h14

`define SSF_CTRL_START  0
`define SSF_STAT_ERR    5

`define SSF_ERR_CODE    16'h1a32
`define SSF_MAX_CHARS   6'h18
`define SSF_MAX_DIGITS  3'h7
`define SSF_EXP_SAT     12'h063

`define SSF_CH_NUL      8'h00
`define SSF_CH_SPACE    8'h20
`define SSF_CH_PLUS     8'h2b
`define SSF_CH_MINUS    8'h2d
`define SSF_CH_DOT      8'h2e
`define SSF_CH_ZERO     8'h30
`define SSF_CH_NINE     8'h39
`define SSF_CH_EXP      8'h45

`define SSF_BE_INIT     12'h01f
`define SSF_BE_MIN      12'hf82
`define SSF_BE_MAX      12'h080
`define SSF_EXP_BIAS    12'h07f
`define SSF_TENTH       32'hcccccccd
`define SSF_F_MIN       31'h00800000
`define SSF_F_MAX       31'h7f7fffff

`endif

// ---- rtl/ssf_pkg.sv ----
package ssf_pkg;

  typedef enum logic [2:0] {
    S_IDLE,
    S_RD,
    S_CH,
    S_NORM,
    S_SCALE,
    S_PACK
  } ssf_state_e;

  typedef struct packed {
    logic [4:0]  addr;
    logic [15:0] wdata;
    logic        we;
    logic        re;
  } ssf_bus_req_s;

  typedef struct packed {
    logic operation_error_flag;
    logic overflow_carry_flag;
    logic underflow_borrow_flag;
    logic result_zero_flag;
    logic done;
    logic busy;
  } ssf_stat_s;

endpackage : ssf_pkg

// ---- rtl/ssf_str_mem.sv ----
`timescale 1ns/1ns
`include "ssf_defines.svh"

module ssf_str_mem (
  input  wire logic        clk,
  input  wire logic        wr_en,
  input  wire logic [3:0]  wr_addr,
  input  wire logic [15:0] wr_data,
  input  wire logic [3:0]  rd_addr,
  output logic      [15:0] rd_data
);

  logic [15:0] mem [`SSF_STR_WORDS];

  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge clk) begin
    rd_data <= mem[rd_addr];
  end

endmodule : ssf_str_mem

// ---- rtl/ssf_conv.sv ----
// Operation
// [RQ1] exact zero mantissa sets the result zero flag
// [RQ2] magnitude below 2^-126 gives smallest real and sets underflow flag
// [RQ3] magnitude at or above 2^128 gives largest real and sets overflow flag
// [RQ4] any malformed string sets error flag and stores code 6706
// [RQ5] non-digit byte in integer or fraction part is an error
// [RQ6] more than one decimal point is an error
// [RQ7] foreign character or second exponent in exponent part is an error
// [RQ8] no terminating zero byte within the string buffer is an error
// [RQ9] zero characters or more than 24 before terminator is an error
// [RQ10] two characters per word, low byte first, sign first, zero byte ends
// [RQ11] keep first seven significant digits, drop the rest
// [RQ12] minus sign means negative, plus or no sign means positive
// [RQ13] spaces and leading zeros skipped but still counted as characters
// [RQ14] result low half in first result word, high half in second
//
// The register offsets and the strobed register port were left to the implementer.
`timescale 1ns/1ns
`include "ssf_defines.svh"

module ssf_conv
  import ssf_pkg::*;
(
  input  wire logic         ref_clk,
  input  wire logic         rstn,
  input  wire ssf_bus_req_s bus_req,
  output logic      [15:0]  rd_data,
  output ssf_stat_s         status
);

  logic        rst_meta_q;
  logic        rst_n_q;
  ssf_state_e  state_q;
  logic [5:0]  ci_q;
  logic [5:0]  nch_q;
  logic        neg_q, sig_q, dot_q, ine_q, esgn_q, edig_q, eneg_q, zero_q;
  logic [23:0] mant_q;
  logic [2:0]  ndig_q;
  logic [7:0]  dexp_q;
  logic [11:0] eval_q;
  logic [31:0] m_q;
  logic [11:0] be_q;
  logic [7:0]  cnt_q;
  logic        down_q;
  logic [31:0] result_q;
  logic [15:0] err_word_q;
  logic [15:0] word;
  logic [7:0]  ch;
  logic        is_dig;
  logic [3:0]  dval;
  logic        start, parse_err, fin_err, fin_ok;
  logic [26:0] m10;
  logic [11:0] e10;
  logic [11:0] tot;
  logic [63:0] prod;
  logic [32:0] up;
  logic [11:0] fexp;

  // flop pair: first stage feeds only the second
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      rst_meta_q <= 1'b0;
      rst_n_q    <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n_q    <= rst_meta_q;
    end
  end

  // buffer writes refused while converting so the scan sees a stable string
  ssf_str_mem u_mem (
    .clk     (ref_clk),
    .wr_en   (bus_req.we && !bus_req.addr[4] && !status.busy),
    .wr_addr (bus_req.addr[3:0]),
    .wr_data (bus_req.wdata),
    .rd_addr (ci_q[4:1]),
    .rd_data (word)
  );

  assign start  = bus_req.we && bus_req.addr == `SSF_REG_CTRL && bus_req.wdata[`SSF_CTRL_START] && !status.busy;
  assign ch     = ci_q[0] ? word[15:8] : word[7:0]; // [RQ10]
  assign is_dig = ch >= `SSF_CH_ZERO && ch <= `SSF_CH_NINE;
  assign dval   = ch[3:0];
  assign m10    = {mant_q, 3'h0} + {2'h0, mant_q, 1'h0} + {23'h0, dval};
  assign e10    = {eval_q[8:0], 3'h0} + {eval_q[10:0], 1'h0} + {8'h0, dval};
  assign tot    = {{4{dexp_q[7]}}, dexp_q} + (eneg_q ? 12'h000 - eval_q : eval_q); // [RQ12]
  assign prod   = m_q * `SSF_TENTH;
  assign up     = {1'h0, m_q} + {3'h0, m_q[31:2]};
  assign fexp   = be_q + `SSF_EXP_BIAS;

  always_comb begin
    parse_err = 1'b0;
    if (ch == `SSF_CH_NUL) begin
      parse_err = nch_q == 6'h00; // [RQ9]
    end else if (nch_q == `SSF_MAX_CHARS) begin
      parse_err = 1'b1; // [RQ9]
    end else if (!ine_q) begin
      if (ch == `SSF_CH_DOT) begin
        parse_err = dot_q; // [RQ6]
      end else if (!(is_dig || ch == `SSF_CH_SPACE || ch == `SSF_CH_EXP ||
                     (ci_q == 6'h00 && (ch == `SSF_CH_PLUS || ch == `SSF_CH_MINUS)))) begin
        parse_err = 1'b1; // [RQ5]
      end
    end else if (ch == `SSF_CH_PLUS || ch == `SSF_CH_MINUS) begin
      parse_err = esgn_q || edig_q; // [RQ7]
    end else if (!(is_dig || ch == `SSF_CH_SPACE)) begin
      parse_err = 1'b1; // [RQ7]
    end
  end

  assign fin_err = (state_q == S_CH && parse_err) || (state_q == S_RD && ci_q == `SSF_CI_END); // [RQ8]
  assign fin_ok  = state_q == S_PACK;

  always_ff @(posedge ref_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      state_q <= S_IDLE;
      ci_q    <= 6'h00;
      nch_q   <= 6'h00;
      {neg_q, sig_q, dot_q, ine_q, esgn_q, edig_q, eneg_q, zero_q, down_q} <= 9'h000;
      mant_q  <= 24'h000000;
      ndig_q  <= 3'h0;
      dexp_q  <= 8'h00;
      eval_q  <= 12'h000;
      m_q     <= 32'h00000000;
      be_q    <= 12'h000;
      cnt_q   <= 8'h00;
    end else begin
      unique case (state_q)
        S_IDLE: begin
          if (start) begin
            state_q <= S_RD;
            ci_q    <= 6'h00;
            nch_q   <= 6'h00;
            {neg_q, sig_q, dot_q, ine_q, esgn_q, edig_q, eneg_q} <= 7'h00;
            mant_q  <= 24'h000000;
            ndig_q  <= 3'h0;
            dexp_q  <= 8'h00;
            eval_q  <= 12'h000;
          end
        end
        S_RD: begin
          state_q <= fin_err ? S_IDLE : S_CH;
        end
        S_CH: begin
          if (parse_err) begin
            state_q <= S_IDLE;
          end else if (ch == `SSF_CH_NUL) begin
            m_q     <= {8'h00, mant_q};
            be_q    <= `SSF_BE_INIT;
            down_q  <= tot[11];
            cnt_q   <= tot[11] ? 8'(12'h000 - tot) : tot[7:0];
            zero_q  <= mant_q == 24'h000000;
            state_q <= mant_q == 24'h000000 ? S_PACK : S_NORM;
          end else begin
            state_q <= S_RD;
            ci_q    <= ci_q + 6'h01;
            nch_q   <= nch_q + 6'h01; // [RQ13]
            if (!ine_q) begin
              if (ci_q == 6'h00 && (ch == `SSF_CH_PLUS || ch == `SSF_CH_MINUS)) begin
                neg_q <= ch == `SSF_CH_MINUS; // [RQ12]
              end else if (ch == `SSF_CH_DOT) begin
                dot_q <= 1'b1;
              end else if (ch == `SSF_CH_EXP) begin
                ine_q <= 1'b1;
              end else if (is_dig) begin
                if (!sig_q && ch == `SSF_CH_ZERO) begin
                  dexp_q <= dot_q ? dexp_q - 8'h01 : dexp_q; // [RQ13]
                end else if (ndig_q < `SSF_MAX_DIGITS) begin
                  sig_q  <= 1'b1;
                  mant_q <= m10[23:0];
                  ndig_q <= ndig_q + 3'h1;
                  dexp_q <= dot_q ? dexp_q - 8'h01 : dexp_q;
                end else begin
                  dexp_q <= dot_q ? dexp_q : dexp_q + 8'h01; // [RQ11]
                end
              end
            end else if (ch == `SSF_CH_PLUS || ch == `SSF_CH_MINUS) begin
              esgn_q <= 1'b1;
              eneg_q <= ch == `SSF_CH_MINUS; // [RQ12]
            end else if (is_dig) begin
              edig_q <= 1'b1;
              // huge exponents saturate; they clamp anyway
              eval_q <= e10 > `SSF_EXP_SAT ? `SSF_EXP_SAT : e10;
            end
          end
        end
        S_NORM: begin
          if (m_q[31]) begin
            state_q <= S_SCALE;
          end else begin
            m_q  <= {m_q[30:0], 1'h0};
            be_q <= be_q - 12'h001;
          end
        end
        S_SCALE: begin
          if (cnt_q == 8'h00) begin
            state_q <= S_PACK;
          end else begin
            cnt_q <= cnt_q - 8'h01;
            // divide by ten as times 0.8 then /8; truncation may lose an ulp
            if (down_q) begin
              m_q  <= prod[63] ? prod[63:32] : {prod[62:32], 1'h0};
              be_q <= prod[63] ? be_q - 12'h003 : be_q - 12'h004;
            end else begin
              m_q  <= up[32] ? up[32:1] : up[31:0];
              be_q <= up[32] ? be_q + 12'h004 : be_q + 12'h003;
            end
          end
        end
        S_PACK: begin
          state_q <= S_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      status     <= '0;
      result_q   <= 32'h00000000;
      err_word_q <= 16'h0000;
    end else begin
      if (start) begin
        status <= '{busy: 1'b1, default: 1'b0};
      end else begin
        if (bus_req.we && bus_req.addr == `SSF_REG_STAT && bus_req.wdata[`SSF_STAT_ERR]) begin
          status.operation_error_flag <= 1'b0;
        end
        if (fin_err) begin
          status.busy                 <= 1'b0;
          status.done                 <= 1'b1;
          status.operation_error_flag <= 1'b1; // [RQ4]
          err_word_q                  <= `SSF_ERR_CODE; // [RQ4]
        end
        if (fin_ok) begin
          status.busy <= 1'b0;
          status.done <= 1'b1;
          if (zero_q) begin
            result_q                <= 32'h00000000;
            status.result_zero_flag <= 1'b1; // [RQ1]
          end else if ($signed(be_q) < $signed(`SSF_BE_MIN)) begin
            result_q                     <= {neg_q, `SSF_F_MIN}; // [RQ2]
            status.underflow_borrow_flag <= 1'b1; // [RQ2]
          end else if ($signed(be_q) >= $signed(`SSF_BE_MAX)) begin
            result_q                   <= {neg_q, `SSF_F_MAX}; // [RQ3]
            status.overflow_carry_flag <= 1'b1; // [RQ3]
          end else begin
            result_q <= {neg_q, fexp[7:0], m_q[30:8]};
          end
        end
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      rd_data <= 16'h0000;
    end else if (bus_req.re) begin
      unique case (bus_req.addr)
        `SSF_REG_STAT:   rd_data <= {10'h000, status};
        `SSF_REG_RES_LO: rd_data <= result_q[15:0]; // [RQ14]
        `SSF_REG_RES_HI: rd_data <= result_q[31:16]; // [RQ14]
        `SSF_REG_ERR:    rd_data <= err_word_q;
        default:         rd_data <= 16'h0000;
      endcase
    end else begin
      rd_data <= 16'h0000;
    end
  end

endmodule : ssf_conv

// ---- dv/ssf_conv_checker.sv ----
`timescale 1ns/1ns
`include "ssf_defines.svh"
module ssf_conv_checker
  import ssf_pkg::*;
(
  input wire logic         ref_clk,
  input wire logic         rstn,
  input wire ssf_bus_req_s bus_req,
  input wire logic [15:0]  rd_data,
  input wire ssf_stat_s    status
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  rd_idle_a: assert property (!$past(bus_req.re) |-> rd_data == 16'h0)
    else $error("read data not idle");
  stat_rd_a: assert property ($past(bus_req.re && bus_req.addr == `SSF_REG_STAT)
    |-> rd_data == {10'h0, $past(status)}) else $error("status read wrong");
  err_code_a: assert property ($past(bus_req.re && bus_req.addr == `SSF_REG_ERR
    && status.operation_error_flag) |-> rd_data == 16'h1a32) else $error("error code wrong");
  start_busy_a: assert property ($past(bus_req.we && bus_req.addr == `SSF_REG_CTRL
    && bus_req.wdata[0] && !status.busy) |-> status.busy) else $error("start not taken");
  busy_bound_a: assert property ($rose(status.busy) |-> ##[1:600] !status.busy)
    else $error("conversion hangs");
  finish_done_a: assert property ($fell(status.busy) |-> status.done) else $error("done missing");
  flag_excl_a: assert property ($onehot0(status[5:2]))
    else $error("status flags clash");
  start_clr_a: assert property ($rose(status.busy) |-> status[5:1] == 5'h0)
    else $error("flags kept at start");
  err_stop_a: assert property ($rose(status.operation_error_flag) |-> ##[0:1] !status.busy)
    else $error("error did not stop");
  cover property ($rose(status.underflow_borrow_flag));
  cover property ($rose(status.overflow_carry_flag));
  cover property ($rose(status.operation_error_flag));
  cover property ($rose(status.result_zero_flag));
  cover property ($fell(status.busy) && !status.operation_error_flag);
endmodule : ssf_conv_checker

bind ssf_conv ssf_conv_checker u_chk (.ref_clk(ref_clk), .rstn(rstn), .bus_req(bus_req),
  .rd_data(rd_data), .status(status));

// ---- dv/tb_ascii_string_to_float.sv ----
`timescale 1ns/1ns
`include "ssf_defines.svh"
module tb_ascii_string_to_float import ssf_pkg::*; ;
  logic         ref_clk  = 1'b0;
  logic         rstn     = 1'b0;
  ssf_bus_req_s bus_req  = '0;
  logic [15:0]  rd_data;
  ssf_stat_s    status;
  int           n_errors = 0;
  int           cmp_count = 0;
  int           cyc      = 0;
  logic [31:0]  last_res = 32'h0;

  always #25 ref_clk = ~ref_clk;

  ssf_conv dut (.ref_clk(ref_clk), .rstn(rstn), .bus_req(bus_req), .rd_data(rd_data), .status(status));

  task end_of_test;
    $display("errors %0d compares %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : end_of_test

  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      n_errors++;
      end_of_test();
    end
  end

  task check(string nm, logic [31:0] seen, logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  task wr(logic [4:0] a, logic [15:0] d);
    @(posedge ref_clk);
    bus_req <= '{a, d, 1'b1, 1'b0};
    @(posedge ref_clk);
    bus_req.we <= 1'b0;
  endtask : wr

  // data stands only in the cycle after the strobe
  task rd(logic [4:0] a, output logic [15:0] d);
    @(posedge ref_clk);
    bus_req <= '{a, 16'h0, 1'b0, 1'b1};
    @(posedge ref_clk);
    bus_req.re <= 1'b0;
    #1 d = rd_data;
  endtask : rd

  // integers below 2^24 are exact, so no rounding to model
  function logic [31:0] to_f(bit neg, int v);
    int e;
    e = $clog2(v + 1) - 1;
    return {neg, 8'(127 + e), 23'(v << (23 - e))};
  endfunction : to_f

  task run(string s, bit noterm, logic [31:0] res, logic [3:0] fl);
    logic [15:0] w;
    logic [15:0] lo;
    logic [15:0] hi;
    logic [7:0]  b[2];
    for (int k = 0; k < 16; k++) begin
      for (int j = 0; j < 2; j++)
        b[j] = (2 * k + j < s.len()) ? s[2*k+j] : (noterm ? 8'h31 : 8'h00);
      wr(5'(k), {b[1], b[0]});
    end
    wr(`SSF_REG_CTRL, 16'h0001);
    w = 16'h0001;
    for (int i = 0; i < 400 && w[0] !== 1'b0; i++)
      rd(`SSF_REG_STAT, w);
    check("stat", 32'(w[5:0]), 32'({fl, 2'b10}));
    if (fl[3])
      res = last_res;
    rd(`SSF_REG_RES_LO, lo);
    rd(`SSF_REG_RES_HI, hi);
    check("result", {hi, lo}, res);
    last_res = res;
    if (fl[3]) begin
      rd(`SSF_REG_ERR, w);
      check("code", 32'(w), 32'h1a32);
      wr(`SSF_REG_STAT, 16'h0020);
      rd(`SSF_REG_STAT, w);
      check("clear", 32'(w), 32'h2);
    end
  endtask : run

  initial begin
    string       z;
    int          v;
    bit          ng;
    logic [15:0] w;
    v = $urandom(40);
    repeat (5) @(posedge ref_clk);
    rstn <= 1'b1;
    repeat (3) @(posedge ref_clk);
    run("1", 0, 32'h3f800000, 4'h0);
    run("-1.5", 0, 32'hbfc00000, 4'h0);
    run("+2.5E1", 0, 32'h41c80000, 4'h0);
    run("5E+0", 0, 32'h40a00000, 4'h0);
    run("+ 0 12", 0, 32'h41400000, 4'h0);
    run("12345678", 0, 32'h4b3c6146, 4'h0);
    run("0", 0, 32'h0, 4'h1);
    run("1E-99", 0, 32'h00800000, 4'h2);
    run("-1E99", 0, 32'hff7fffff, 4'h4);
    run("1A", 0, 0, 4'h8);
    run("1.2.3", 0, 0, 4'h8);
    run("1E1E1", 0, 0, 4'h8);
    run("1E+x", 0, 0, 4'h8);
    run("1", 1, 0, 4'h8);
    run("", 0, 0, 4'h8);
    z = "+";
    for (int i = 0; i < 22; i++)
      z = {z, "0"};
    run({z, "1"}, 0, 32'h3f800000, 4'h0);
    run({z, "01"}, 0, 0, 4'h8);
    repeat (8) begin
      v = int'($urandom_range(9999999, 1));
      ng = 1'($urandom_range(1, 0));
      run($sformatf("%s%0d", ng ? "-" : "+", v), 0, to_f(ng, v), 4'h0);
    end
    rd(5'($urandom_range(31, 21)), w);
    check("unmapped", 32'(w), 32'h0);
    rd(5'h03, w);
    check("buffer", 32'(w), 32'h0);
    // reset while idle must wipe result and sticky code
    @(posedge ref_clk);
    rstn <= 1'b0;
    repeat (3) @(posedge ref_clk);
    rstn <= 1'b1;
    repeat (3) @(posedge ref_clk);
    rd(`SSF_REG_RES_HI, w);
    check("reset result", 32'(w), 32'h0);
    rd(`SSF_REG_ERR, w);
    check("reset code", 32'(w), 32'h0);
    end_of_test();
  end
endmodule : tb_ascii_string_to_float
